// [include/ext_bus_defines.svh]
// Purpose: Named constants for the external address/data bus pin controller.
// Assumes: 20 MHz system clock, one clock domain.
// Notes: Types live in ext_bus_pkg.
`ifndef EXT_BUS_DEFINES_SVH
`define EXT_BUS_DEFINES_SVH

`define INT_ADDR_W 24
`define EXT_ADDR_W 20
`define DATA_W 16
`define UPPER_LSB 16
`define UPPER_MSB 19
`define RESET_FETCH_INT 24'hFF2080
`define RESET_FETCH_EXT 24'h0F2080
`define ADDR_PHASE_CYC 2'h1
`define DATA_PHASE_CYC 2'h2

`endif

// [include/ext_bus_pkg.sv]
// Purpose: Types shared by the external bus pin controller.
// Assumes: Included after ext_bus_defines.svh.
// Notes: None.
package ext_bus_pkg;
  typedef enum logic [1:0] {MODE_MUX16, MODE_MUX8, MODE_DEMUX16, MODE_DEMUX8} bus_mode_t;
  typedef enum {ST_IDLE, ST_ADDR, ST_DATA} bus_state_t;
endpackage

// [rtl/ext_bus_pins.sv]
// Purpose: Drives the external address, shared address/data and latch strobe pins for one bus cycle.
// Assumes: Requests and port-function values are synchronous to clk_sys_i.
// Notes: One cycle address phase, two cycle data phase; no wait states.
// Contract
// - Low address lines carry address bits 0 to 15 for the whole external cycle in all modes.
// - Upper address lines carry address bits 16 to 19 for the whole external cycle.
// - Internal addresses are 24 bits wide but only the low 20 bits reach the pins.
// - After reset the fetch address is FF2080h for internal execution or F2080h for external.
// - Upper address pins double as extended port pins 3 to 0.
// - With no external access in progress the shared pins serve as general port pins.
// - 16-bit multiplexed: shared lines carry address first, then data.
// - 8-bit multiplexed: upper shared byte holds address 15:8 all cycle, lower byte address then data.
// - 16-bit demultiplexed: shared lines carry only data all cycle.
// - 8-bit demultiplexed: lower byte is data, upper byte shows the internal bus high byte.
// - The latch strobe pulses only for external cycles.
// - The latch strobe marks the cycle start while a valid address is on the pins.
// - The latch strobe is confined to the address phase and drops before the cycle ends.
// - High byte enable low and bit zero select bytes: 00 both, 01 high, 10 low.
`timescale 1ns/1ps
`include "ext_bus_defines.svh"

module ext_bus_pins
(
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic boot_external_i,
  input wire logic req_i,
  input wire logic [`INT_ADDR_W-1:0] req_addr_i,
  input wire logic req_external_i,
  input wire logic req_write_i,
  input wire logic req_word_i,
  input wire ext_bus_pkg::bus_mode_t req_mode_i,
  input wire logic [`DATA_W-1:0] wdata_i,
  input wire logic [`DATA_W-1:0] int_bus_i,
  input wire logic [`DATA_W-1:0] shared_in_i,
  input wire logic [`DATA_W-1:0] port_out_i,
  input wire logic [`DATA_W-1:0] port_oe_i,
  input wire logic [3:0] extended_port_out_i,
  input wire logic [3:0] extended_port_oe_i,
  output logic [`INT_ADDR_W-1:0] reset_fetch_o,
  output logic busy_o,
  output logic done_o,
  output logic [`DATA_W-1:0] rdata_o,
  output logic [15:0] low_address_lines_o,
  output logic [3:0] upper_address_lines_o,
  output logic [3:0] upper_address_lines_oe_o,
  output logic [`DATA_W-1:0] shared_addr_data_lines_o,
  output logic [`DATA_W-1:0] shared_addr_data_lines_oe_o,
  output logic address_latch_o,
  output logic high_byte_enable_n_o
);
  import ext_bus_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  bus_state_t state_reg, state_next;
  bus_mode_t mode_reg, mode_next;
  logic [`EXT_ADDR_W-1:0] addr_reg, addr_next;
  logic [`DATA_W-1:0] wdata_reg, wdata_next;
  logic write_reg, write_next;
  logic word_reg, word_next;
  logic [1:0] cnt_reg, cnt_next;
  logic done_reg, done_next;
  logic [`DATA_W-1:0] rdata_reg, rdata_next;
  logic [`INT_ADDR_W-1:0] fetch_reg, fetch_next;
  logic fetch_taken_reg, fetch_taken_next;

  always_comb
  begin
    state_next = state_reg;
    mode_next = mode_reg;
    addr_next = addr_reg;
    wdata_next = wdata_reg;
    write_next = write_reg;
    word_next = word_reg;
    cnt_next = cnt_reg;
    done_next = 1'b0;
    rdata_next = rdata_reg;
    fetch_next = fetch_reg;
    fetch_taken_next = 1'b1;
    // The boot strap is sampled on the first clock after reset release.
    if (!fetch_taken_reg)
    begin
      fetch_next = boot_external_i ? `RESET_FETCH_EXT : `RESET_FETCH_INT;
    end
    unique case (state_reg)
      ST_IDLE:
      begin
        // Internal accesses never touch the pins, so they never start a cycle.
        if (req_i && req_external_i)
        begin
          state_next = ST_ADDR;
          mode_next = req_mode_i;
          addr_next = req_addr_i[`EXT_ADDR_W-1:0];
          wdata_next = wdata_i;
          write_next = req_write_i;
          word_next = req_word_i;
          cnt_next = `ADDR_PHASE_CYC;
        end
      end
      ST_ADDR:
      begin
        cnt_next = cnt_reg - 2'h1;
        if (cnt_reg == `ADDR_PHASE_CYC)
        begin
          state_next = ST_DATA;
          cnt_next = `DATA_PHASE_CYC;
        end
      end
      ST_DATA:
      begin
        cnt_next = cnt_reg - 2'h1;
        if (cnt_reg == 2'h1)
        begin
          state_next = ST_IDLE;
          done_next = 1'b1;
          if (!write_reg)
          begin
            rdata_next = shared_in_i;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      state_reg <= ST_IDLE;
      mode_reg <= MODE_MUX16;
      addr_reg <= '0;
      wdata_reg <= '0;
      write_reg <= 1'b0;
      word_reg <= 1'b0;
      cnt_reg <= 2'h0;
      done_reg <= 1'b0;
      rdata_reg <= '0;
      fetch_reg <= `RESET_FETCH_INT;
      fetch_taken_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      mode_reg <= mode_next;
      addr_reg <= addr_next;
      wdata_reg <= wdata_next;
      write_reg <= write_next;
      word_reg <= word_next;
      cnt_reg <= cnt_next;
      done_reg <= done_next;
      rdata_reg <= rdata_next;
      fetch_reg <= fetch_next;
      fetch_taken_reg <= fetch_taken_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin values are computed from the next state so every pin leaves a flip-flop.
  logic [15:0] low_next;
  logic [3:0] upper_next, upper_oe_next;
  logic [`DATA_W-1:0] ad_next, ad_oe_next;
  logic ale_next, bhe_n_next;
  logic [15:0] low_reg;
  logic [3:0] upper_reg, upper_oe_reg;
  logic [`DATA_W-1:0] ad_reg, ad_oe_reg;
  logic ale_reg, bhe_n_reg;
  logic busy_reg;
  logic in_cycle, out_phase;

  always_comb
  begin
    in_cycle = (state_next != ST_IDLE);
    out_phase = write_next;
    low_next = low_reg;
    upper_next = extended_port_out_i;
    upper_oe_next = extended_port_oe_i;
    ad_next = port_out_i;
    ad_oe_next = port_oe_i;
    ale_next = 1'b0;
    bhe_n_next = 1'b1;
    if (in_cycle)
    begin
      low_next = addr_next[15:0];
      upper_next = addr_next[`UPPER_MSB:`UPPER_LSB];
      upper_oe_next = 4'hF;
      ale_next = (state_next == ST_ADDR);
      // Byte lanes: a word needs bit zero low; a single byte picks its lane by bit zero.
      bhe_n_next = !((mode_next == MODE_MUX16 || mode_next == MODE_DEMUX16) && (word_next || addr_next[0]));
      unique case (mode_next)
        MODE_MUX16:
        begin
          ad_next = (state_next == ST_ADDR) ? addr_next[15:0] : wdata_next;
          ad_oe_next = (state_next == ST_ADDR || out_phase) ? 16'hFFFF : 16'h0000;
        end
        MODE_MUX8:
        begin
          ad_next[15:8] = addr_next[15:8];
          ad_next[7:0] = (state_next == ST_ADDR) ? addr_next[7:0] : wdata_next[7:0];
          ad_oe_next = {8'hFF, (state_next == ST_ADDR || out_phase) ? 8'hFF : 8'h00};
        end
        MODE_DEMUX16:
        begin
          ad_next = wdata_next;
          ad_oe_next = out_phase ? 16'hFFFF : 16'h0000;
        end
        MODE_DEMUX8:
        begin
          ad_next = {int_bus_i[15:8], wdata_next[7:0]};
          ad_oe_next = {8'hFF, out_phase ? 8'hFF : 8'h00};
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      low_reg <= '0;
      upper_reg <= '0;
      upper_oe_reg <= '0;
      ad_reg <= '0;
      ad_oe_reg <= '0;
      ale_reg <= 1'b0;
      bhe_n_reg <= 1'b1;
      busy_reg <= 1'b0;
    end
    else
    begin
      low_reg <= low_next;
      upper_reg <= upper_next;
      upper_oe_reg <= upper_oe_next;
      ad_reg <= ad_next;
      ad_oe_reg <= ad_oe_next;
      ale_reg <= ale_next;
      bhe_n_reg <= bhe_n_next;
      busy_reg <= in_cycle;
    end
  end

  assign reset_fetch_o = fetch_reg;
  // Busy is registered from the next state, so it equals a compare of the state but leaves a flip-flop.
  assign busy_o = busy_reg;
  assign done_o = done_reg;
  assign rdata_o = rdata_reg;
  assign low_address_lines_o = low_reg;
  assign upper_address_lines_o = upper_reg;
  assign upper_address_lines_oe_o = upper_oe_reg;
  assign shared_addr_data_lines_o = ad_reg;
  assign shared_addr_data_lines_oe_o = ad_oe_reg;
  assign address_latch_o = ale_reg;
  assign high_byte_enable_n_o = bhe_n_reg;
endmodule

// [bench/ext_bus_pins_chk.sv]
// Purpose: Pin timing checks for ext_bus_pins.
// Assumes: One clock, async active-low reset.
// Notes: Bound to every instance.
`timescale 1ns/1ps
module ext_bus_pins_chk
(
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic req_i,
  input wire logic req_external_i,
  input wire logic [23:0] req_addr_i,
  input wire ext_bus_pkg::bus_mode_t req_mode_i,
  input wire logic [15:0] port_out_i,
  input wire logic busy_o,
  input wire logic done_o,
  input wire logic [15:0] low_address_lines_o,
  input wire logic [3:0] upper_address_lines_o,
  input wire logic [3:0] upper_address_lines_oe_o,
  input wire logic [15:0] shared_addr_data_lines_o,
  input wire logic address_latch_o,
  input wire logic high_byte_enable_n_o
);
  import ext_bus_pkg::*;
  wire logic [19:0] ext_addr = req_addr_i[19:0];
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!resetn_i);
  chk_latch_pulse: assert property (address_latch_o |=> !address_latch_o)
    else $error("strobe too long");
  chk_latch_cause: assert property (
    address_latch_o |-> $past(req_i) && $past(req_external_i) && !$past(busy_o))
    else $error("strobe without request");
  chk_cycle_len: assert property (address_latch_o |-> ##3 done_o)
    else $error("cycle length wrong");
  chk_addr_value: assert property (
    address_latch_o |-> {upper_address_lines_o, low_address_lines_o} == $past(ext_addr))
    else $error("address wrong");
  chk_addr_hold: assert property (
    address_latch_o |=> ($stable(low_address_lines_o) && $stable(upper_address_lines_o)) [*2])
    else $error("address moved");
  chk_upper_drive: assert property (address_latch_o |-> upper_address_lines_oe_o == 4'hF)
    else $error("upper lines not driven");
  chk_mux_addr: assert property (
    address_latch_o && $past(req_mode_i) inside {MODE_MUX16, MODE_MUX8} |->
    shared_addr_data_lines_o == low_address_lines_o)
    else $error("no address on shared lines");
  chk_idle_port: assert property (
    !busy_o && $past(resetn_i) |-> shared_addr_data_lines_o == $past(port_out_i))
    else $error("idle pins not port");
  chk_hbe_narrow: assert property (
    address_latch_o && $past(req_mode_i) inside {MODE_MUX8, MODE_DEMUX8} |-> high_byte_enable_n_o)
    else $error("byte enable in 8-bit mode");
  cover property (done_o ##1 address_latch_o);
  cover property (address_latch_o && !high_byte_enable_n_o);
  cover property (done_o);
endmodule
bind ext_bus_pins ext_bus_pins_chk u_chk (.clk_sys_i, .resetn_i, .req_i, .req_external_i, .req_addr_i, .req_mode_i,
  .port_out_i, .busy_o, .done_o, .low_address_lines_o, .upper_address_lines_o, .upper_address_lines_oe_o,
  .shared_addr_data_lines_o, .address_latch_o, .high_byte_enable_n_o);

// [bench/ext_mem_model.sv]
// Purpose: External memory on the shared lines.
// Assumes: Read data is the latched address XOR 5A3C.
// Notes: Released lines show a pattern that toggles every cycle.
`timescale 1ns/1ps
module ext_mem_model
(
  input wire logic clk_i,
  input wire logic latch_i,
  input wire logic [15:0] addr_lines_i,
  input wire logic [7:0] oe_low_i,
  output logic [15:0] data_o
);
  logic [15:0] addr_reg = 16'h0;
  logic [15:0] last_reg = 16'h0;
  logic [1:0] cnt_reg = 2'h0;
  always_ff @(posedge clk_i)
  begin
    if (latch_i)
      addr_reg <= addr_lines_i;
    if (latch_i)
      cnt_reg <= 2'h2;
    else if (cnt_reg != 2'h0)
      cnt_reg <= cnt_reg - 2'h1;
    last_reg <= data_o;
  end
  assign data_o = (cnt_reg != 2'h0 && oe_low_i == 8'h0) ? addr_reg ^ 16'h5A3C : ~last_reg;
endmodule

// [bench/tb_top.sv]
// Purpose: Self-checking bench for ext_bus_pins.
// Assumes: Inputs change on the falling edge.
// Notes: Table rows first, then edge cases.
`timescale 1ns/1ps
module tb_top;
  import ext_bus_pkg::*;
  typedef struct {bus_mode_t m; logic [2:0] f; logic [23:0] a;} row_t;
  logic clk_sys_i = 1'b0;
  logic resetn_i = 1'b0;
  logic boot = 1'b0, req = 1'b0, ext = 1'b1, wr = 1'b0, word = 1'b0, busy, done, ale, hbe;
  logic [23:0] addr = 24'h0, fetch;
  logic [15:0] wdata = 16'hC35A, intb = 16'h9E00, pout = 16'h1248, poe = 16'h0F0F, sin, rdata, low, sh, shoe;
  logic [3:0] eout = 4'h9, eoe = 4'h6, up, upoe;
  bus_mode_t mode = MODE_MUX16, cur = MODE_MUX16;
  int err_total = 0, tests_run = 0, n;
  row_t rows[9] = '{'{MODE_MUX16, 3'h6, 24'hAB2468}, '{MODE_MUX16, 3'h2, 24'h0F2080}, '{MODE_MUX8, 3'h5, 24'h01357A},
    '{MODE_MUX8, 3'h1, 24'h0C1234}, '{MODE_DEMUX16, 3'h6, 24'h05AAAA}, '{MODE_DEMUX16, 3'h0, 24'h0F0011},
    '{MODE_DEMUX16, 3'h1, 24'h0F0010}, '{MODE_DEMUX8, 3'h5, 24'h07FFFF}, '{MODE_DEMUX8, 3'h1, 24'h000000}};
  always #25 clk_sys_i = ~clk_sys_i;
  ext_bus_pins DUT (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .boot_external_i(boot), .req_i(req),
    .req_addr_i(addr), .req_external_i(ext), .req_write_i(wr), .req_word_i(word), .req_mode_i(mode),
    .wdata_i(wdata), .int_bus_i(intb), .shared_in_i(sin), .port_out_i(pout), .port_oe_i(poe),
    .extended_port_out_i(eout), .extended_port_oe_i(eoe), .reset_fetch_o(fetch), .busy_o(busy), .done_o(done),
    .rdata_o(rdata), .low_address_lines_o(low), .upper_address_lines_o(up), .upper_address_lines_oe_o(upoe),
    .shared_addr_data_lines_o(sh), .shared_addr_data_lines_oe_o(shoe), .address_latch_o(ale),
    .high_byte_enable_n_o(hbe));
  ext_mem_model u_mem (.clk_i(clk_sys_i), .latch_i(ale), .addr_lines_i(cur[1] ? low : sh), .oe_low_i(shoe[7:0]),
    .data_o(sin));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic cmp(input logic [23:0] g, input logic [23:0] e);
    tests_run++;
    if (g !== e)
    begin
      err_total++;
      $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic finish_test();
    $display("errors %0d checks %0d", err_total, tests_run);
    if (err_total == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic do_reset(input logic b);
    resetn_i = 1'b0;
    boot = b;
    repeat (10) @(negedge clk_sys_i);
    resetn_i = 1'b1;
    @(negedge clk_sys_i);
  endtask
  // The mode input is scrambled after the taking edge, so the pins must follow the captured mode.
  task automatic xfer(input row_t r);
    logic [15:0] mask;
    mask = (r.f[1] && !r.m[0]) ? 16'hFFFF : 16'h00FF;
    @(negedge clk_sys_i);
    {wr, word, addr, req} = {r.f[2:1], r.a, 1'b1};
    mode = r.m;
    cur = r.m;
    @(negedge clk_sys_i);
    req = 1'b0;
    mode = bus_mode_t'(~r.m);
    cmp(ale, 1'b1);
    cmp(busy, 1'b1);
    cmp({up, low}, r.a[19:0]);
    cmp(upoe, 4'hF);
    cmp(hbe, r.f[0]);
    if (r.m == MODE_DEMUX16 && r.f[2]) cmp(sh, wdata);
    @(negedge clk_sys_i);
    cmp(ale, 1'b0);
    cmp({up, low}, r.a[19:0]);
    if (r.f[2])
    begin
      cmp(sh, r.m[0] ? {(r.m[1] ? intb[15:8] : r.a[15:8]), wdata[7:0]} : wdata);
      cmp(shoe, 16'hFFFF);
    end
    else
    begin
      cmp(shoe, {(r.m[0] ? 8'hFF : 8'h00), 8'h00});
    end
    n = 0;
    while (done !== 1'b1 && n < 8)
    begin
      @(negedge clk_sys_i);
      n++;
    end
    cmp(n, 2);
    if (n == 8) finish_test();
    if (!r.f[2]) cmp(rdata & mask, (r.a[15:0] ^ 16'h5A3C) & mask);
    cmp(busy, 1'b0);
    cmp({up, sh}, {eout, pout});
    cmp({upoe, shoe}, {eoe, poe});
  endtask
  initial
  begin
    do_reset(1'b0);
    cmp(fetch, 24'hFF2080);
    foreach (rows[i]) xfer(rows[i]);
    req = 1'b1;
    addr = 24'h0A0002;
    ext = 1'b0;
    n = 0;
    repeat (4) @(negedge clk_sys_i) n += ale;
    cmp(n, 0);
    cmp(busy, 1'b0);
    ext = 1'b1;
    repeat (9) @(negedge clk_sys_i) n += ale;
    cmp(n, 3);
    req = 1'b0;
    do_reset(1'b1);
    cmp(fetch, 24'h0F2080);
    finish_test();
  end
endmodule
